// File: dv/fan_duty_source_and_throttle_ctrl_props.sv
// Port assertions for the fan duty source and throttle block
`timescale 1ns/1ps
module fan_duty_props
#(
    parameter TICK_DIV         = 4,
    parameter WATCH_BASE_TICKS = 5
)
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [9:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  fan_drive_out1,
    input wire logic        cpu1_hot_pin_out,
    input wire logic        cpu2_hot_pin_out,
    input wire logic        cpu1_hot_pin_oe_n,
    input wire logic        cpu1_watch_strobe
);
    logic [15:0] gap;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles since the last watch strobe
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            gap <= 16'h0000;
        else
            gap <= cpu1_watch_strobe ? 16'h0000 : gap + 16'h0001;
    a_ready_after_setup: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready is not a one-cycle answer to setup");
    a_ready_has_cause: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("pready without a setup cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
        else $error("prdata not zero while idle");
    a_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
        else $error("misaligned access not refused");
    a_unmapped_err: assert property (psel && !penable && paddr == 10'h314 |=> pslverr)
        else $error("unmapped access not refused");
    a_reserved_zero: assert property (pready && !pwrite && paddr == 10'h318 |-> prdata[5:4] == 2'b00)
        else $error("reserved throttle bits read nonzero");
    a_duty_table: assert property (fan_drive_out1[7:4] == fan_drive_out1[3:0])
        else $error("fan duty off the code table");
    a_pin_open_drain: assert property (!cpu1_hot_pin_out && !cpu2_hot_pin_out)
        else $error("hot pin driven high");
    a_pulse_min_width: assert property ($fell(cpu1_hot_pin_oe_n) |=> !cpu1_hot_pin_oe_n [*8])
        else $error("throttle pulse too short");
    a_strobe_spacing: assert property (cpu1_watch_strobe |-> gap >= (WATCH_BASE_TICKS - 1) * TICK_DIV)
        else $error("watch strobes too close");
endmodule

bind fan_duty_source_and_throttle_ctrl fan_duty_props #(.TICK_DIV(TICK_DIV),
    .WATCH_BASE_TICKS(WATCH_BASE_TICKS)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fan_drive_out1(fan_drive_out1),
    .cpu1_hot_pin_out(cpu1_hot_pin_out), .cpu2_hot_pin_out(cpu2_hot_pin_out),
    .cpu1_hot_pin_oe_n(cpu1_hot_pin_oe_n), .cpu1_watch_strobe(cpu1_watch_strobe));

// File: dv/fan_duty_source_and_throttle_ctrl_tb_top.sv
// Self-checking bench for fan duty arbitration, throttle pulses and watch strobes
`timescale 1ns/1ps
`include "fan_duty_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module fan_duty_source_and_throttle_ctrl_tb_top;
    localparam TD = 4;
    localparam WB = 5;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] zone_temp = 32'h10101010;
    logic [31:0] zone_base_temp = 32'h50505050;
    logic [15:0] zone_lut_code = 16'h0000;
    logic [3:0]  hot = 4'h0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [7:0]  fan;
    wire  [1:0]  o, oe, pin, hin, stb;
    int          mismatches = 0;
    int          num_checks = 0;
    logic [31:0] rdv;
    logic        errv;
    logic [7:0]  ri [6] = '{8'hC3, 8'hC4, 8'hC6, 8'hC7, 8'hC8, 8'hF0};
    logic [7:0]  rr [6] = '{8'h00, 8'h00, 8'h00, 8'h11, 8'h0F, 8'h00};

    fan_duty_source_and_throttle_ctrl #(.TICK_DIV(TD), .RAMP_STEP_TICKS(3),
        .WATCH_BASE_TICKS(WB)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .zone_temp(zone_temp), .zone_base_temp(zone_base_temp), .zone_lut_code(zone_lut_code),
        .cpu1_hot_in(hin[0]), .cpu2_hot_in(hin[1]), .regulator_hot_in1(hot[2]),
        .regulator_hot_in2(hot[3]), .fan_drive_out1(fan), .cpu1_hot_pin_out(o[0]),
        .cpu1_hot_pin_oe_n(oe[0]), .cpu2_hot_pin_out(o[1]), .cpu2_hot_pin_oe_n(oe[1]),
        .cpu1_watch_strobe(stb[0]), .cpu2_watch_strobe(stb[1]));
    hot_pin_partner partner (
        .cpu1_hot_pin_out(o[0]), .cpu1_hot_pin_oe_n(oe[0]), .cpu2_hot_pin_out(o[1]),
        .cpu2_hot_pin_oe_n(oe[1]), .proc1_hot_req(hot[0]), .proc2_hot_req(hot[1]),
        .cpu1_hot_pin(pin[0]), .cpu2_hot_pin(pin[1]), .cpu1_hot_in(hin[0]), .cpu2_hot_in(hin[1]));

    initial
    begin
        forever #10 pclk = ~pclk;
    end

    function automatic logic [9:0] adr(input logic [7:0] i);
        return {i, 2'b00};
    endfunction

    function automatic logic [7:0] fexp(input logic [3:0] b, input logic [3:0] a,
                                        input logic [3:0] c);
        logic [3:0] m;
        m = 4'h0;
        if ((b[0] || b[1]) && a > m)
            m = a;
        if ((b[2] || b[3]) && c > m)
            m = c;
        return {m, m};
    endfunction

    task acc(input logic wr, input logic [9:0] a, input logic [7:0] d);
        int n;
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= {24'h000000, d};
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end
            while (pready !== 1'b1 && n < 16);
            rdv = prdata;
            errv = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
            if (n >= 16)
                mismatches++;
        end
    endtask

    task thr(input logic [7:0] ctl, input logic sh);
        int c1;
        int c2;
        logic [1:0] f;
        begin
            f = ctl[7:6] | {2{sh & (|ctl[7:6])}};
            c1 = 0;
            c2 = 0;
            acc(1'b1, adr(8'hC6), 8'h00);
            acc(1'b1, adr(8'hF0), {7'h00, sh});
            acc(1'b1, adr(8'hC6), ctl);
            repeat (2) @(posedge pclk);
            `CHK(pin, ~f)
            repeat (8) @(posedge pclk);
            repeat (80 * TD)
            begin
                @(posedge pclk);
                c1 += !pin[0];
                c2 += !pin[1];
            end
            `CHK(c1, f[0] ? 5 * TD * (ctl[3:0] + 1) : 0)
            `CHK(c2, f[1] ? 5 * TD * (ctl[3:0] + 1) : 0)
        end
    endtask

    task gap(input int s, input logic [3:0] c);
        int n;
        begin
            repeat (2)
            begin
                n = 0;
                do
                begin
                    @(posedge pclk);
                    n++;
                end
                while (stb[s] !== 1'b1 && n < 25000);
            end
            `CHK(n, (TD * WB) << ((c > 9) ? 9 : c))
        end
    endtask

    task results;
        begin
            $display("checks %0d mismatches %0d", num_checks, mismatches);
            if (mismatches == 0 && num_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // Longest run is about 22k cycles, dominated by the reserved interval code
    initial
    begin
        #(60000 * 20);
        mismatches++;
        results;
    end

    initial
    begin
        int i;
        logic [7:0] d, f, b;
        void'($urandom(32'h6d470787));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 6; i++)
        begin
            acc(1'b0, adr(ri[i]), 8'h00);
            `CHK(rdv[7:0], rr[i])
        end
        acc(1'b0, adr(8'hC5), 8'h00);
        `CHK({errv, rdv}, 33'h100000000)
        acc(1'b1, adr(8'hC8) | 10'h001, 8'hF0);
        `CHK(errv, 1'b1)
        acc(1'b0, adr(8'hC8), 8'h00);
        `CHK(rdv[7:0], 8'h0F)
        for (i = 0; i < 5; i++)
        begin
            // Force bits stay clear here so no throttle pulse is cut short later
            d = (i == 2) ? {2'b00, 6'($urandom)} : 8'($urandom);
            acc(1'b1, adr(ri[i]), d);
            acc(1'b0, adr(ri[i]), 8'h00);
            `CHK(rdv[7:0], (i == 2) ? (d & 8'hCF) : d)
        end
        for (i = 0; i < 8; i++)
        begin
            d = $urandom;
            f = $urandom;
            b = (i == 0) ? 8'h0F : {4'h0, 4'($urandom)};
            acc(1'b1, adr(8'hC3), {d[7:4], d[3:0] | 4'h1});
            acc(1'b1, adr(8'hC4), {f[7:4], f[3:0] | 4'h1});
            acc(1'b1, adr(8'hC8), b);
            repeat (4) @(posedge pclk);
            `CHK(fan, fexp(b[3:0], d[7:4], f[7:4]))
        end
        acc(1'b1, adr(8'hC3), 8'h01);
        acc(1'b1, adr(8'hC4), 8'h01);
        acc(1'b1, adr(8'hBF), 8'h00);
        for (i = 0; i < 4; i++)
        begin
            acc(1'b1, adr(8'hC8), 8'h10 << i);
            hot <= 4'h1 << i;
            repeat (6) @(posedge pclk);
            `CHK(fan, 8'hFF)
            hot <= ~(4'h1 << i);
            repeat (6) @(posedge pclk);
            `CHK(fan, 8'h00)
        end
        acc(1'b1, adr(8'hBF), 8'h01);
        hot <= 4'h8;
        repeat (30) @(posedge pclk);
        `CHK(fan == 8'hFF, 1'b0)
        repeat (200) @(posedge pclk);
        `CHK(fan, 8'hFF)
        hot <= 4'h0;
        acc(1'b1, adr(8'hC8), 8'h01);
        acc(1'b1, adr(8'hC3), 8'h04);
        zone_base_temp <= 32'h50505020;
        zone_temp <= 32'h10101040;
        zone_lut_code <= 16'h0008;
        repeat (6) @(posedge pclk);
        `CHK(fan, 8'h88)
        zone_temp <= 32'h1010103E;
        zone_lut_code <= 16'h0005;
        repeat (6) @(posedge pclk);
        `CHK(fan, 8'h88)
        zone_temp <= 32'h1010103B;
        repeat (6) @(posedge pclk);
        `CHK(fan, 8'h55)
        acc(1'b0, adr(8'hF1), 8'h00);
        `CHK(rdv[7:0], 8'h55)
        for (i = 0; i < 3; i++)
        begin
            d = (i == 0) ? 8'h00 : (i == 2) ? 8'h0F : {4'h0, 4'($urandom % 15)};
            thr({i == 1, i != 1, 2'b00, d[3:0]}, i == 2);
        end
        acc(1'b1, adr(8'hC6), 8'h00);
        acc(1'b1, adr(8'hF0), 8'h00);
        for (i = 0; i < 2; i++)
        begin
            d = (i == 0) ? 8'h20 : 8'h1A;
            acc(1'b1, adr(8'hC7), d);
            gap(0, d[3:0]);
            gap(1, d[7:4]);
        end
        results;
    end
endmodule

// File: dv/hot_pin_partner.sv
// Processor side of the two open-drain hot pins, with board pull-ups
`timescale 1ns/1ps
module hot_pin_partner
(
    input  wire logic cpu1_hot_pin_out,
    input  wire logic cpu1_hot_pin_oe_n,
    input  wire logic cpu2_hot_pin_out,
    input  wire logic cpu2_hot_pin_oe_n,
    input  wire logic proc1_hot_req,
    input  wire logic proc2_hot_req,
    output wire logic cpu1_hot_pin,
    output wire logic cpu2_hot_pin,
    output wire logic cpu1_hot_in,
    output wire logic cpu2_hot_in
);
    // Pull-up wins unless the device or the processor pulls low
    assign cpu1_hot_pin = (cpu1_hot_pin_oe_n ? 1'b1 : cpu1_hot_pin_out) & !proc1_hot_req;
    assign cpu2_hot_pin = (cpu2_hot_pin_oe_n ? 1'b1 : cpu2_hot_pin_out) & !proc2_hot_req;
    assign cpu1_hot_in = proc1_hot_req;
    assign cpu2_hot_in = proc2_hot_req;
endmodule

// File: src/fan_duty_consts.vh
// Register map, field positions, reset values and timing counts for fan duty control
`ifndef FAN_DUTY_CONSTS_VH
`define FAN_DUTY_CONSTS_VH

// Register indexes; byte address is four times the index
`define IDX_RAMP_DELAY      8'hBF
`define IDX_ZONE12          8'hC3
`define IDX_ZONE34          8'hC4
`define IDX_THROTTLE        8'hC6
`define IDX_INTERVAL        8'hC7
`define IDX_BINDING         8'hC8
`define IDX_HOT_SHORT       8'hF0
`define IDX_FAN_STATUS      8'hF1

// Field positions
`define HYST_LSB            0
`define FLOOR_LSB           4
`define DUTY_CODE_LSB       0
`define FORCE_CPU1_BIT      6
`define FORCE_CPU2_BIT      7
`define INTERVAL1_LSB       0
`define INTERVAL2_LSB       4
`define REG_RAMP_LSB        0
`define CPU_RAMP_LSB        4
`define SHORT_BIT           0
`define THROTTLE_USED_MASK  8'hCF

// Reset values
`define RST_ZONE12          8'h00
`define RST_ZONE34          8'h00
`define RST_THROTTLE        8'h00
`define RST_INTERVAL        8'h11
`define RST_BINDING         8'h0F
`define RST_RAMP_DELAY      8'h00
`define RST_HOT_SHORT       8'h00

// Timing
`define CLK_HZ              50000000
`define TICK_HZ             22500
`define TICK_DIV            (`CLK_HZ / `TICK_HZ)
`define THROTTLE_PERIOD     80
`define THROTTLE_STEP       5
`define RAMP_STEP_MS        50
`define RAMP_STEP_TICKS     (`RAMP_STEP_MS * `TICK_HZ / 1000)
`define WATCH_BASE_MS       730
`define WATCH_BASE_TICKS    (`WATCH_BASE_MS * `TICK_HZ / 1000)
`define WATCH_MAX_CODE      4'h9

// Duty code table: duty = code * scale, code F is full duty
`define DUTY_CODE_MAX       4'hF
`define DUTY_SCALE          8'h11

`endif

// File: src/fan_duty_source_and_throttle_ctrl.v
// Fan 1 duty source arbitration, forced throttle pulse train and hot-watch intervals
`timescale 1ns/1ps
`include "fan_duty_consts.vh"
module fan_duty_source_and_throttle_ctrl
#(
    parameter TICK_DIV         = `TICK_DIV,
    parameter RAMP_STEP_TICKS  = `RAMP_STEP_TICKS,
    parameter WATCH_BASE_TICKS = `WATCH_BASE_TICKS
)
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [9:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [31:0] zone_temp,
    input  wire [31:0] zone_base_temp,
    input  wire [15:0] zone_lut_code,
    input  wire        cpu1_hot_in,
    input  wire        cpu2_hot_in,
    input  wire        regulator_hot_in1,
    input  wire        regulator_hot_in2,
    output reg  [7:0]  fan_drive_out1,
    output reg         cpu1_hot_pin_out,
    output reg         cpu1_hot_pin_oe_n,
    output reg         cpu2_hot_pin_out,
    output reg         cpu2_hot_pin_oe_n,
    output reg         cpu1_watch_strobe,
    output reg         cpu2_watch_strobe
);

    // Register file
    reg  [7:0]  zone12_floor_duty_hysteresis;
    reg  [7:0]  zone34_floor_duty_hysteresis;
    reg  [7:0]  throttle_force_control;
    reg  [7:0]  hot_watch_interval;
    reg  [7:0]  fan1_source_binding;
    reg  [7:0]  ramp_delay_control;
    reg  [7:0]  hot_pin_control;

    wire        setup_phase;
    wire        write_done;
    wire [7:0]  reg_index;
    reg  [7:0]  next_rdata;
    reg         next_err;

    assign setup_phase = psel && !penable;
    assign write_done  = psel && penable && pready && pwrite;
    assign reg_index   = paddr[9:2];

    always @*
    begin
        next_rdata = 8'h00;
        next_err   = 1'b0;
        case (reg_index)
            `IDX_RAMP_DELAY: next_rdata = ramp_delay_control;
            `IDX_ZONE12:     next_rdata = zone12_floor_duty_hysteresis;
            `IDX_ZONE34:     next_rdata = zone34_floor_duty_hysteresis;
            `IDX_THROTTLE:   next_rdata = throttle_force_control;
            `IDX_INTERVAL:   next_rdata = hot_watch_interval;
            `IDX_BINDING:    next_rdata = fan1_source_binding;
            `IDX_HOT_SHORT:  next_rdata = hot_pin_control;
            `IDX_FAN_STATUS: next_rdata = fan_drive_out1;
            default:         next_err   = 1'b1;
        endcase
        if (paddr[1:0] != 2'b00)
        begin
            next_err = 1'b1;
        end
    end

    // Answer registered in setup, one access cycle, no wait states
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata  <= (pwrite || next_err) ? 32'h0000_0000 : {24'h00_0000, next_rdata};
            pready  <= 1'b1;
            pslverr <= next_err;
        end
        else
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            zone12_floor_duty_hysteresis <= `RST_ZONE12;
            zone34_floor_duty_hysteresis <= `RST_ZONE34;
            throttle_force_control       <= `RST_THROTTLE;
            hot_watch_interval           <= `RST_INTERVAL;
            fan1_source_binding          <= `RST_BINDING;
            ramp_delay_control           <= `RST_RAMP_DELAY;
            hot_pin_control              <= `RST_HOT_SHORT;
        end
        else if (write_done && !pslverr)
        begin
            case (reg_index)
                `IDX_RAMP_DELAY: ramp_delay_control <= pwdata[7:0];
                `IDX_ZONE12:     zone12_floor_duty_hysteresis <= pwdata[7:0];
                `IDX_ZONE34:     zone34_floor_duty_hysteresis <= pwdata[7:0];
                `IDX_THROTTLE:   throttle_force_control <= pwdata[7:0] & `THROTTLE_USED_MASK;
                `IDX_INTERVAL:   hot_watch_interval <= pwdata[7:0];
                `IDX_BINDING:    fan1_source_binding <= pwdata[7:0];
                `IDX_HOT_SHORT:  hot_pin_control <= {7'h00, pwdata[`SHORT_BIT]};
                default:         hot_pin_control <= hot_pin_control;
            endcase
        end
    end

    // Field views
    wire [3:0] autofan_hysteresis12 = zone12_floor_duty_hysteresis[`HYST_LSB +: 4];
    wire [3:0] autofan_hysteresis34 = zone34_floor_duty_hysteresis[`HYST_LSB +: 4];
    wire [3:0] floor_duty_code12    = zone12_floor_duty_hysteresis[`FLOOR_LSB +: 4];
    wire [3:0] floor_duty_code34    = zone34_floor_duty_hysteresis[`FLOOR_LSB +: 4];
    wire [3:0] throttle_duty_code   = throttle_force_control[`DUTY_CODE_LSB +: 4];
    wire       force_throttle_cpu1  = throttle_force_control[`FORCE_CPU1_BIT];
    wire       force_throttle_cpu2  = throttle_force_control[`FORCE_CPU2_BIT];
    wire [3:0] cpu1_watch_interval  = hot_watch_interval[`INTERVAL1_LSB +: 4];
    wire [3:0] cpu2_watch_interval  = hot_watch_interval[`INTERVAL2_LSB +: 4];
    wire [3:0] cpu_hot_ramp_delay   = ramp_delay_control[`CPU_RAMP_LSB +: 4];
    wire [3:0] regulator_ramp_delay = ramp_delay_control[`REG_RAMP_LSB +: 4];
    wire       hot_pin_short_enable = hot_pin_control[`SHORT_BIT];

    // Internal 22.5 kHz tick
    reg  [15:0] tick_div;
    reg         tick;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_div <= 16'h0000;
            tick     <= 1'b0;
        end
        else if (tick_div == TICK_DIV[15:0] - 16'h0001)
        begin
            tick_div <= 16'h0000;
            tick     <= 1'b1;
        end
        else
        begin
            tick_div <= tick_div + 16'h0001;
            tick     <= 1'b0;
        end
    end

    // Forced throttle pulse train
    reg  [6:0] throttle_phase;
    reg        force_prev1;
    reg        force_prev2;
    wire       force_rise;
    wire [6:0] asserted_ticks;
    wire       pulse_on;
    wire       drive_cpu1;
    wire       drive_cpu2;

    assign force_rise     = (force_throttle_cpu1 && !force_prev1)
                          || (force_throttle_cpu2 && !force_prev2);
    assign asserted_ticks = 7'd`THROTTLE_STEP * ({3'b000, throttle_duty_code} + 7'd1);
    assign pulse_on       = throttle_phase < asserted_ticks;
    assign drive_cpu1     = pulse_on && (force_throttle_cpu1
                          || (hot_pin_short_enable && force_throttle_cpu2));
    assign drive_cpu2     = pulse_on && (force_throttle_cpu2
                          || (hot_pin_short_enable && force_throttle_cpu1));

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            throttle_phase <= 7'd0;
            force_prev1    <= 1'b0;
            force_prev2    <= 1'b0;
        end
        else
        begin
            force_prev1 <= force_throttle_cpu1;
            force_prev2 <= force_throttle_cpu2;
            if (force_rise)
            begin
                throttle_phase <= 7'd0;
            end
            else if (tick)
            begin
                if (throttle_phase == 7'd`THROTTLE_PERIOD - 7'd1)
                begin
                    throttle_phase <= 7'd0;
                end
                else
                begin
                    throttle_phase <= throttle_phase + 7'd1;
                end
            end
        end
    end

    // Active-low open-drain hot pins: pulled low while oe_n is low
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu1_hot_pin_out  <= 1'b0;
            cpu1_hot_pin_oe_n <= 1'b1;
            cpu2_hot_pin_out  <= 1'b0;
            cpu2_hot_pin_oe_n <= 1'b1;
        end
        else
        begin
            cpu1_hot_pin_out  <= 1'b0;
            cpu1_hot_pin_oe_n <= !drive_cpu1;
            cpu2_hot_pin_out  <= 1'b0;
            cpu2_hot_pin_oe_n <= !drive_cpu2;
        end
    end

    // Hot input monitoring intervals; reserved codes act as the longest one
    reg  [23:0] watch_count1;
    reg  [23:0] watch_count2;
    wire [3:0]  watch_code1;
    wire [3:0]  watch_code2;
    wire [23:0] watch_limit1;
    wire [23:0] watch_limit2;
    wire        interval_write;

    assign watch_code1  = (cpu1_watch_interval > `WATCH_MAX_CODE) ? `WATCH_MAX_CODE
                        : cpu1_watch_interval;
    assign watch_code2  = (cpu2_watch_interval > `WATCH_MAX_CODE) ? `WATCH_MAX_CODE
                        : cpu2_watch_interval;
    assign watch_limit1 = WATCH_BASE_TICKS[23:0] << watch_code1;
    assign watch_limit2 = WATCH_BASE_TICKS[23:0] << watch_code2;
    assign interval_write = write_done && !pslverr && (reg_index == `IDX_INTERVAL);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            watch_count1      <= 24'h00_0000;
            watch_count2      <= 24'h00_0000;
            cpu1_watch_strobe <= 1'b0;
            cpu2_watch_strobe <= 1'b0;
        end
        else
        begin
            cpu1_watch_strobe <= 1'b0;
            cpu2_watch_strobe <= 1'b0;
            if (interval_write)
            begin
                watch_count1 <= 24'h00_0000;
                watch_count2 <= 24'h00_0000;
            end
            else if (tick)
            begin
                if (watch_count1 >= watch_limit1 - 24'h00_0001)
                begin
                    watch_count1      <= 24'h00_0000;
                    cpu1_watch_strobe <= 1'b1;
                end
                else
                begin
                    watch_count1 <= watch_count1 + 24'h00_0001;
                end
                if (watch_count2 >= watch_limit2 - 24'h00_0001)
                begin
                    watch_count2      <= 24'h00_0000;
                    cpu2_watch_strobe <= 1'b1;
                end
                else
                begin
                    watch_count2 <= watch_count2 + 24'h00_0001;
                end
            end
        end
    end

    // Zone duty requests through the lookup step and floor duty
    wire [15:0] zone_code;

    genvar z;
    generate
        for (z = 0; z < 4; z = z + 1)
        begin : zones
            zone_step_hold u_zone
            (
                .pclk       (pclk),
                .presetn    (presetn),
                .temp       (zone_temp[8*z +: 8]),
                .base_temp  (zone_base_temp[8*z +: 8]),
                .lut_code   (zone_lut_code[4*z +: 4]),
                .hysteresis ((z < 2) ? autofan_hysteresis12 : autofan_hysteresis34),
                .floor_code ((z < 2) ? floor_duty_code12 : floor_duty_code34),
                .code       (zone_code[4*z +: 4])
            );
        end
    endgenerate

    // Hot input ramp engines: cpu1, cpu2, regulator1, regulator2
    wire [3:0]  hot_level  = {regulator_hot_in2, regulator_hot_in1, cpu2_hot_in, cpu1_hot_in};
    wire [15:0] ramp_code;

    genvar r;
    generate
        for (r = 0; r < 4; r = r + 1)
        begin : ramps
            reg  [3:0]  level;
            reg  [15:0] wait_ticks;
            wire [3:0]  delay_code = (r < 2) ? cpu_hot_ramp_delay : regulator_ramp_delay;
            wire [15:0] step_ticks = delay_code * RAMP_STEP_TICKS[11:0];
            wire        step_due   = tick && (wait_ticks >= step_ticks - 16'h0001);

            assign ramp_code[4*r +: 4] = level;

            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    level      <= 4'h0;
                    wait_ticks <= 16'h0000;
                end
                else if (delay_code == 4'h0)
                begin
                    level      <= hot_level[r] ? `DUTY_CODE_MAX : 4'h0;
                    wait_ticks <= 16'h0000;
                end
                else if (step_due)
                begin
                    wait_ticks <= 16'h0000;
                    if (hot_level[r] && level != `DUTY_CODE_MAX)
                    begin
                        level <= level + 4'h1;
                    end
                    else if (!hot_level[r] && level != 4'h0)
                    begin
                        level <= level - 4'h1;
                    end
                end
                else if (tick)
                begin
                    wait_ticks <= wait_ticks + 16'h0001;
                end
            end
        end
    endgenerate

    // Largest request among bound sources wins
    reg [3:0] next_code;
    integer   k;

    always @*
    begin
        next_code = 4'h0;
        for (k = 0; k < 4; k = k + 1)
        begin
            if (fan1_source_binding[k] && zone_code[4*k +: 4] > next_code)
            begin
                next_code = zone_code[4*k +: 4];
            end
            if (fan1_source_binding[k+4] && ramp_code[4*k +: 4] > next_code)
            begin
                next_code = ramp_code[4*k +: 4];
            end
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fan_drive_out1 <= 8'h00;
        end
        else
        begin
            fan_drive_out1 <= {4'h0, next_code} * `DUTY_SCALE;
        end
    end

endmodule

// File: src/zone_step_hold.v
// One temperature zone: floor duty below base, lookup step with hysteresis above
`timescale 1ns/1ps
module zone_step_hold
(
    input  wire       pclk,
    input  wire       presetn,
    input  wire [7:0] temp,
    input  wire [7:0] base_temp,
    input  wire [3:0] lut_code,
    input  wire [3:0] hysteresis,
    input  wire [3:0] floor_code,
    output reg  [3:0] code
);

    reg  [7:0] edge_temp;
    wire [8:0] temp_plus_hyst;

    assign temp_plus_hyst = {1'b0, temp} + {5'h00, hysteresis};

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            code      <= 4'h0;
            edge_temp <= 8'h00;
        end
        else if (temp < base_temp)
        begin
            code      <= floor_code;
            edge_temp <= temp;
        end
        else if (lut_code > code)
        begin
            code      <= lut_code;
            edge_temp <= temp;
        end
        else if ((lut_code < code) && (temp_plus_hyst < {1'b0, edge_temp}))
        begin
            // Step down only once temperature falls hysteresis below the step edge
            code      <= lut_code;
            edge_temp <= temp;
        end
    end

endmodule
